// ### design/slk_status_led_key.sv
`timescale 1ns/1ps
// Function
// - unrecoverable fault: module indicator steady red
// - power-up self test: module indicator alternates green and red
// - no IP address: network indicator dark
// - IP set, no connection, no timeout: network indicator flashes green
// - IP set, connection up, no timeout: network indicator steady green
// - exclusive owner connection timed out: network indicator flashes red
// - timeout ends once all exclusive owner connections are back
// - duplicate IP detected: network indicator steady red
// - power-up self test: network indicator alternates green and red
// - key press starts dark correction by default
// - key unlocked by default; may be deactivated or locked to ignore presses
// - key held over 10 s restores factory settings
// - operational about 3 s after power-up
// - start in last saved operating mode, industrial-Ethernet by default
// - DHCP addressing by default, static address selectable later
// - proper operation: module indicator steady green
// - not configured: module indicator flashes green
// - recoverable fault: module indicator flashes red
module slk_status_led_key
	import slk_pkg::*;
#(
	parameter int unsigned FLASH_HALF_CYC = slk_pkg::FLASH_HALF_CYC_D,
	parameter int unsigned STARTUP_CYC = slk_pkg::STARTUP_CYC_D,
	parameter int unsigned KEY_HOLD_CYC = slk_pkg::KEY_HOLD_CYC_D
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// conditions from firmware and network stack
	input wire logic fault_unrec,
	input wire logic fault_rec,
	input wire logic configured,
	input wire logic ip_assigned,
	input wire logic cip_connected,
	input wire logic eo_timeout_evt,
	input wire logic eo_all_restored,
	input wire logic dup_ip,
	// front key and saved mode
	input wire logic key_in,
	input wire logic saved_mode_valid,
	input wire logic saved_mode,
	// indicators and actions
	output slk_pkg::slk_led_s module_health_indicator,
	output slk_pkg::slk_led_s network_link_indicator,
	output logic dark_corr_start,
	output logic factory_restore,
	output logic operational,
	output logic ip_static_mode,
	output logic op_mode,
	output logic irq
);
	import slk_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic slk_led_s led_drive(input logic g, input logic r, input logic fl, input logic alt,
		input logic ph);
		slk_led_s l;
		if (alt) begin
			l.green = ph;
			l.red = ~ph;
		end else if (fl) begin
			l.green = g & ph;
			l.red = r & ph;
		end else begin
			l.green = g;
			l.red = r;
		end
		return l;
	endfunction

	function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
		return CNT_W'(v + 1'b1);
	endfunction

	// ****************************************
	// state
	// ****************************************
	slk_state_s state_reg;
	slk_state_s state_next;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] clr;
	logic key_ok;
	logic flash_tick;
	logic rd_pend;
	logic [31:0] rd_val;

	// a read waits one cycle so that hrdata comes from a flop
	assign rd_pend = state_reg.ph.valid && !state_reg.ph.write && !state_reg.rd_done;

	always_comb begin
		state_next = state_reg;
		state_next.dark_pulse = 1'b0;
		state_next.fact_pulse = 1'b0;
		ev = '0;
		clr = '0;
		rd_val = '0;

		// saved mode is caught once, on the first edge after reset release
		if (!state_reg.strap_done) begin
			state_next.strap_done = 1'b1;
			state_next.ctrl.op_mode = saved_mode_valid ? saved_mode : OPM_EIP;
		end

		// start-up self test window
		if (!state_reg.operational) begin
			if (state_reg.boot_cnt == CNT_W'(STARTUP_CYC - 1)) begin
				state_next.operational = 1'b1;
			end else begin
				state_next.boot_cnt = inc(state_reg.boot_cnt);
			end
		end

		// flash divider
		// shared by both lamps so that their flashes stay in step
		flash_tick = (state_reg.flash_cnt == CNT_W'(FLASH_HALF_CYC - 1));
		if (flash_tick) begin
			state_next.flash_cnt = '0;
			state_next.flash_ph = ~state_reg.flash_ph;
		end else begin
			state_next.flash_cnt = inc(state_reg.flash_cnt);
		end

		// key: ignored while deactivated, locked or still in self test
		key_ok = (state_reg.ctrl.key_mode == KEY_NORMAL) && state_reg.operational;
		state_next.key_prev = key_in;
		if (key_ok && key_in) begin
			if (!state_reg.key_prev) begin
				state_next.dark_pulse = 1'b1;
			end
			// count parks at the limit: one restore per hold, however long
			if (!state_reg.hold_done) begin
				if (state_reg.hold_cnt == CNT_W'(KEY_HOLD_CYC)) begin
					state_next.fact_pulse = 1'b1;
					state_next.hold_done = 1'b1;
				end else begin
					state_next.hold_cnt = inc(state_reg.hold_cnt);
				end
			end
		end else begin
			state_next.hold_cnt = '0;
			state_next.hold_done = 1'b0;
		end

		// connection timeout flag; a new timeout wins over restore
		// a flag, since the timeout event may last a single cycle
		if (eo_all_restored || !ip_assigned) begin
			state_next.tmo_flag = 1'b0;
		end
		if (ip_assigned && eo_timeout_evt) begin
			state_next.tmo_flag = 1'b1;
		end
		state_next.dup_prev = dup_ip;

		// module health state
		if (fault_unrec) begin
			state_next.mh = MH_UNREC;
		end else if (!state_reg.operational) begin
			state_next.mh = MH_SELFTEST;
		end else if (fault_rec) begin
			state_next.mh = MH_REC;
		end else if (!configured) begin
			state_next.mh = MH_STANDBY;
		end else begin
			state_next.mh = MH_OK;
		end

		// network state, highest priority first
		if (!state_reg.operational) begin
			state_next.nl = NL_SELFTEST;
		end else if (dup_ip) begin
			state_next.nl = NL_DUP;
		end else if (state_reg.tmo_flag) begin
			state_next.nl = NL_TMO;
		end else if (ip_assigned && cip_connected) begin
			state_next.nl = NL_CONN;
		end else if (ip_assigned) begin
			state_next.nl = NL_NOCONN;
		end else begin
			state_next.nl = NL_DARK;
		end

		unique case (state_next.mh)
			MH_SELFTEST: state_next.mh_led = led_drive(1'b0, 1'b0, 1'b0, 1'b1, state_reg.flash_ph);
			MH_UNREC: state_next.mh_led = led_drive(1'b0, 1'b1, 1'b0, 1'b0, state_reg.flash_ph);
			MH_REC: state_next.mh_led = led_drive(1'b0, 1'b1, 1'b1, 1'b0, state_reg.flash_ph);
			MH_STANDBY: state_next.mh_led = led_drive(1'b1, 1'b0, 1'b1, 1'b0, state_reg.flash_ph);
			MH_OK: state_next.mh_led = led_drive(1'b1, 1'b0, 1'b0, 1'b0, state_reg.flash_ph);
		endcase

		unique case (state_next.nl)
			NL_SELFTEST: state_next.nl_led = led_drive(1'b0, 1'b0, 1'b0, 1'b1, state_reg.flash_ph);
			NL_DUP: state_next.nl_led = led_drive(1'b0, 1'b1, 1'b0, 1'b0, state_reg.flash_ph);
			NL_TMO: state_next.nl_led = led_drive(1'b0, 1'b1, 1'b1, 1'b0, state_reg.flash_ph);
			NL_CONN: state_next.nl_led = led_drive(1'b1, 1'b0, 1'b0, 1'b0, state_reg.flash_ph);
			NL_NOCONN: state_next.nl_led = led_drive(1'b1, 1'b0, 1'b1, 1'b0, state_reg.flash_ph);
			NL_DARK: state_next.nl_led = led_drive(1'b0, 1'b0, 1'b0, 1'b0, state_reg.flash_ph);
		endcase

		// bus data phase
		if (state_reg.ph.valid && state_reg.ph.write) begin
			unique case (state_reg.ph.addr)
				OFS_CTRL: state_next.ctrl = hwdata[CTRL_W-1:0];
				OFS_IRQ_CLR: clr = hwdata[IRQ_W-1:0];
				OFS_IRQ_EN: state_next.irq_en = hwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		if (rd_pend) begin
			unique case (state_reg.ph.addr)
				OFS_CTRL: rd_val[CTRL_W-1:0] = state_reg.ctrl;
				OFS_STATUS: begin
					rd_val[ST_OPER] = state_reg.operational;
					rd_val[ST_TMO] = state_reg.tmo_flag;
					rd_val[ST_KEY] = state_reg.key_prev;
					rd_val[ST_MH_LSB +: $bits(slk_mh_e)] = state_reg.mh;
					rd_val[ST_NL_LSB +: $bits(slk_nl_e)] = state_reg.nl;
				end
				OFS_IRQ_STAT: rd_val[IRQ_W-1:0] = state_reg.irq_stat;
				OFS_IRQ_EN: rd_val[IRQ_W-1:0] = state_reg.irq_en;
				default: rd_val = '0;
			endcase
			state_next.hrdata = rd_val;
			state_next.rd_done = 1'b1;
		end

		// factory restore overrides a software write in the same cycle
		if (state_next.fact_pulse) begin
			state_next.ctrl = CTRL_RST;
		end

		// bus address phase
		if (hready) begin
			state_next.ph.valid = hsel && htrans[HTRANS_ACT_BIT];
			state_next.ph.write = hwrite;
			state_next.ph.addr = haddr[ADDR_W-1:0];
			state_next.rd_done = 1'b0;
		end

		// sticky events: set wins over clear
		ev[IRQ_OPER] = state_next.operational & ~state_reg.operational;
		ev[IRQ_DARK] = state_next.dark_pulse;
		ev[IRQ_FACT] = state_next.fact_pulse;
		ev[IRQ_TMO] = state_next.tmo_flag & ~state_reg.tmo_flag;
		ev[IRQ_DUP] = dup_ip & ~state_reg.dup_prev;
		state_next.irq_stat = (state_reg.irq_stat & ~clr) | ev;
		state_next.irq = |(state_next.irq_stat & state_next.irq_en);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
			state_reg.ctrl <= CTRL_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// writes need no wait state, reads exactly one
	assign hreadyout = !rd_pend;
	assign hresp = 1'b0;
	assign hrdata = state_reg.hrdata;
	assign module_health_indicator = state_reg.mh_led;
	assign network_link_indicator = state_reg.nl_led;
	assign dark_corr_start = state_reg.dark_pulse;
	assign factory_restore = state_reg.fact_pulse;
	assign operational = state_reg.operational;
	assign ip_static_mode = state_reg.ctrl.ip_static;
	assign op_mode = state_reg.ctrl.op_mode;
	assign irq = state_reg.irq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// the release edge still samples reset state, hence hresetn in some antecedents
	a_unrec_red: assert property (hresetn && fault_unrec |=> module_health_indicator == 2'h1)
		else $error("unrecoverable fault not steady red");
	a_mh_selftest: assert property (hresetn && !operational && !fault_unrec |=>
		module_health_indicator.green != module_health_indicator.red)
		else $error("module self test not alternating");
	a_nl_dark: assert property (operational && !ip_assigned && !dup_ip && !state_reg.tmo_flag |=>
		network_link_indicator == 2'h0)
		else $error("network indicator lit without address");
	a_noconn_flash: assert property (operational && ip_assigned && !dup_ip && !state_reg.tmo_flag
		&& !cip_connected |=> network_link_indicator.green == $past(state_reg.flash_ph) && !network_link_indicator.red)
		else $error("idle network not flashing green");
	a_conn_green: assert property (operational && ip_assigned && !dup_ip && !state_reg.tmo_flag
		&& cip_connected |=> network_link_indicator == 2'h2)
		else $error("connected network not steady green");
	a_tmo_flash: assert property (operational && !dup_ip && state_reg.tmo_flag |=>
		network_link_indicator.red == $past(state_reg.flash_ph) && !network_link_indicator.green)
		else $error("timeout not flashing red");
	a_tmo_clear: assert property (state_reg.tmo_flag && eo_all_restored && !eo_timeout_evt |=>
		!state_reg.tmo_flag)
		else $error("timeout flag kept after restore");
	a_dup_red: assert property (operational && dup_ip |=> network_link_indicator == 2'h1)
		else $error("duplicate address not steady red");
	a_nl_selftest: assert property (hresetn && !operational |=>
		network_link_indicator.green != network_link_indicator.red)
		else $error("network self test not alternating");
	a_key_press: assert property (operational && state_reg.ctrl.key_mode == KEY_NORMAL && key_in
		&& !state_reg.key_prev |=> dark_corr_start)
		else $error("key press lost");
	a_key_locked: assert property (state_reg.ctrl.key_mode != KEY_NORMAL |=>
		!dark_corr_start && !factory_restore)
		else $error("locked key acted");
	a_factory_hold: assert property (factory_restore |-> $past(state_reg.hold_cnt) == CNT_W'(KEY_HOLD_CYC)
		&& state_reg.ctrl == CTRL_RST)
		else $error("factory restore at wrong time");
	a_boot_time: assert property ($rose(operational) |->
		$past(state_reg.boot_cnt) == CNT_W'(STARTUP_CYC - 1))
		else $error("start-up time wrong");

	// ****************************************
	// lamps, settings and key
	// ****************************************
	a_mh_rec: assert property (operational && !fault_unrec && fault_rec |=>
		module_health_indicator.red == $past(state_reg.flash_ph) && !module_health_indicator.green)
		else $error("recoverable fault not flashing red");
	a_mh_standby: assert property (operational && !fault_unrec && !fault_rec && !configured |=>
		module_health_indicator.green == $past(state_reg.flash_ph) && !module_health_indicator.red)
		else $error("unconfigured module not flashing green");
	a_mh_ok: assert property (operational && !fault_unrec && !fault_rec && configured |=>
		module_health_indicator == 2'h2)
		else $error("healthy module not steady green");
	a_flash_rate: assert property ($changed(state_reg.flash_ph) |->
		$past(state_reg.flash_cnt) == CNT_W'(FLASH_HALF_CYC - 1))
		else $error("flash half period wrong");
	a_conn_restore: assert property (state_reg.tmo_flag && eo_all_restored && !eo_timeout_evt ##1
		operational && ip_assigned && cip_connected && !dup_ip |=> network_link_indicator == 2'h2)
		else $error("restored connection not steady green");
	a_dark_once: assert property (dark_corr_start |=> !dark_corr_start)
		else $error("dark correction pulse too long");
	a_fact_once: assert property (factory_restore |=> !factory_restore)
		else $error("factory restore pulse too long");
	a_hold_clear: assert property (!key_in |=> state_reg.hold_cnt == '0)
		else $error("hold count kept after release");
	a_boot_key: assert property (!operational |=> !dark_corr_start && !factory_restore)
		else $error("key acted during self test");
	a_mode_strap: assert property (hresetn && !state_reg.strap_done |=>
		op_mode == ($past(saved_mode_valid) ? $past(saved_mode) : OPM_EIP))
		else $error("saved operating mode not taken");
	a_static_kept: assert property ($changed(ip_static_mode) |->
		($past(state_reg.ph.valid) && $past(state_reg.ph.write)) || factory_restore)
		else $error("address mode changed without a write");

	c_boot_done: cover property ($rose(operational));
	c_factory: cover property (factory_restore);
	c_timeout: cover property ($rose(state_reg.tmo_flag) ##[1:20] !state_reg.tmo_flag);
	c_dup: cover property (state_reg.nl == NL_DUP);
	c_key_locked: cover property (state_reg.ctrl.key_mode == KEY_LOCK && key_in);

endmodule

// ### inc/slk_pkg.sv
package slk_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_KHZ = 100000;
	localparam int unsigned T_FLASH_HALF_MS = 500;
	localparam int unsigned T_STARTUP_MS = 3000;
	localparam int unsigned T_KEY_HOLD_MS = 10000;
	localparam int unsigned FLASH_HALF_CYC_D = T_FLASH_HALF_MS * CLK_KHZ;
	localparam int unsigned STARTUP_CYC_D = T_STARTUP_MS * CLK_KHZ;
	localparam int unsigned KEY_HOLD_CYC_D = T_KEY_HOLD_MS * CLK_KHZ;
	localparam int CNT_W = 32;

	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h10;
	localparam int HTRANS_ACT_BIT = 1;

	localparam logic [1:0] KEY_NORMAL = 2'h0;
	localparam logic [1:0] KEY_OFF = 2'h1;
	localparam logic [1:0] KEY_LOCK = 2'h2;
	localparam logic IPM_DHCP = 1'h0;
	localparam logic OPM_EIP = 1'h0;
	localparam int CTRL_W = 4;

	localparam int ST_OPER = 0;
	localparam int ST_TMO = 1;
	localparam int ST_KEY = 2;
	localparam int ST_MH_LSB = 4;
	localparam int ST_NL_LSB = 8;

	localparam int IRQ_W = 5;
	localparam int IRQ_OPER = 0;
	localparam int IRQ_DARK = 1;
	localparam int IRQ_FACT = 2;
	localparam int IRQ_TMO = 3;
	localparam int IRQ_DUP = 4;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {MH_SELFTEST, MH_UNREC, MH_REC, MH_STANDBY, MH_OK} slk_mh_e;
	typedef enum logic [2:0] {NL_SELFTEST, NL_DUP, NL_TMO, NL_CONN, NL_NOCONN, NL_DARK} slk_nl_e;

	typedef struct packed {
		logic green;
		logic red;
	} slk_led_s;

	typedef struct packed {
		logic [1:0] key_mode;
		logic ip_static;
		logic op_mode;
	} slk_ctrl_s;

	localparam slk_ctrl_s CTRL_RST = '{key_mode: KEY_NORMAL, ip_static: IPM_DHCP, op_mode: OPM_EIP};

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic write;
		logic valid;
	} slk_ahb_ph_s;

	typedef struct packed {
		logic strap_done;
		logic operational;
		logic [CNT_W-1:0] boot_cnt;
		logic [CNT_W-1:0] flash_cnt;
		logic flash_ph;
		logic key_prev;
		logic [CNT_W-1:0] hold_cnt;
		logic hold_done;
		logic dup_prev;
		logic tmo_flag;
		slk_mh_e mh;
		slk_nl_e nl;
		slk_led_s mh_led;
		slk_led_s nl_led;
		logic dark_pulse;
		logic fact_pulse;
		slk_ctrl_s ctrl;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_en;
		logic irq;
		slk_ahb_ph_s ph;
		logic rd_done;
		logic [31:0] hrdata;
	} slk_state_s;

endpackage

// ### tb/slk_panel_model.sv
`timescale 1ns/1ps
// ********
// front panel: two bicolour lamps and the key
// ********
module slk_panel_model
	import slk_pkg::*;
(
	// clock
	input wire logic hclk,
	// lamps
	input wire slk_pkg::slk_led_s mh_led,
	input wire slk_pkg::slk_led_s nl_led,
	// key, high while pressed
	output logic key_in
);
	initial key_in = 1'b0;

	// no bounce modelled: the design takes the key as synchronous
	task automatic press(input int n);
		key_in <= 1'b1;
		repeat (n) @(posedge hclk);
		key_in <= 1'b0;
	endtask

	// one mask bit per {green,red} code seen; an unknown code sets none
	task automatic watch(output logic [3:0] mh_m, output logic [3:0] nl_m);
		mh_m = 4'h0;
		nl_m = 4'h0;
		repeat (12) begin
			@(posedge hclk);
			mh_m[{mh_led.green, mh_led.red}] = 1'b1;
			nl_m[{nl_led.green, nl_led.red}] = 1'b1;
		end
	endtask
endmodule

// ### tb/status_led_and_key_logic_tb_top.sv
`timescale 1ns/1ps
module status_led_and_key_logic_tb_top;
	import slk_pkg::*;
	localparam int unsigned FLASH = 4;
	localparam int unsigned BOOT = 20;
	localparam int unsigned HOLD = 30;
	localparam logic [7:0] OFS_NONE = 8'h20;
	// lamp masks: 1 dark, 4 green, 2 red, 5/3 flashing, 6 alternating
	localparam logic [2:0] MH_IN [4] = '{3'h1, 3'h0, 3'h3, 3'h7};
	localparam logic [3:0] MH_EXP [4] = '{4'h4, 4'h5, 4'h3, 4'h2};
	localparam logic [4:0] NL_IN [6] = '{5'h00, 5'h10, 5'h18, 5'h1c, 5'h19, 5'h1a};
	localparam logic [3:0] NL_EXP [6] = '{4'h1, 4'h5, 4'h4, 4'h3, 4'h2, 4'h4};
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, key_in;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic fault_unrec, fault_rec, configured, ip_assigned, cip_connected, eo_timeout_evt, eo_all_restored, dup_ip;
	logic saved_mode_valid, saved_mode, dark_corr_start, factory_restore, operational, ip_static_mode, op_mode, irq;
	slk_led_s mh_led, nl_led;
	logic [3:0] mh_m, nl_m;
	int error_cnt = 0;
	int n_checks = 0;
	int dark_n = 0;
	int fact_n = 0;
	int i;

	slk_status_led_key #(.FLASH_HALF_CYC(FLASH), .STARTUP_CYC(BOOT), .KEY_HOLD_CYC(HOLD)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .fault_unrec(fault_unrec), .fault_rec(fault_rec), .configured(configured),
		.ip_assigned(ip_assigned), .cip_connected(cip_connected), .eo_timeout_evt(eo_timeout_evt),
		.eo_all_restored(eo_all_restored), .dup_ip(dup_ip), .key_in(key_in),
		.saved_mode_valid(saved_mode_valid), .saved_mode(saved_mode), .module_health_indicator(mh_led),
		.network_link_indicator(nl_led), .dark_corr_start(dark_corr_start),
		.factory_restore(factory_restore), .operational(operational), .ip_static_mode(ip_static_mode),
		.op_mode(op_mode), .irq(irq));

	slk_panel_model pm (.hclk(hclk), .mh_led(mh_led), .nl_led(nl_led), .key_in(key_in));

	// ********
	// helpers
	// ********
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		if (dark_corr_start === 1'b1) dark_n++;
		if (factory_restore === 1'b1) fact_n++;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// single word transfer, entered just after a rising edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		rd = hrdata;
		if (n >= 40) begin
			chk("bus ready", 32'h1, 32'h0);
			end_of_test();
		end
	endtask

	task automatic do_reset(input logic sv_ok, input logic sv);
		@(posedge hclk);
		hresetn <= 1'b0;
		saved_mode_valid <= sv_ok;
		saved_mode <= sv;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge hclk);
		chk("run length", 32'h0, 32'h1);
		end_of_test();
	end

	// ********
	// main sequence
	// ********
	initial begin
		hresetn = 1'b0;
		hsize = 3'h2;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{fault_unrec, fault_rec, configured, ip_assigned, cip_connected, eo_timeout_evt, eo_all_restored, dup_ip} = '0;
		{saved_mode_valid, saved_mode} = '0;
		do_reset(1'b0, 1'b1);
		repeat (3) @(posedge hclk);
		pm.watch(mh_m, nl_m);
		chk("selftest module lamp", 4'h6, mh_m);
		chk("selftest network lamp", 4'h6, nl_m);
		chk("operational early", 1'b0, operational);
		for (i = 0; i < 40 && operational !== 1'b1; i++) @(posedge hclk);
		chk("start-up window", 1'b1, i + 15 >= BOOT - 1 && i + 15 <= BOOT + 2);
		chk("operating mode default", 1'b0, op_mode);
		chk("address mode default", 1'b0, ip_static_mode);
		ahb(1'b0, OFS_CTRL, 32'h0);
		chk("control reset", 32'h0, rd);
		ahb(1'b1, OFS_CTRL, 32'h2);
		ahb(1'b0, OFS_CTRL, 32'h0);
		chk("control readback", 32'h2, rd);
		chk("static address", 1'b1, ip_static_mode);
		for (i = 0; i < 4; i++) begin
			{fault_unrec, fault_rec, configured} <= MH_IN[i];
			repeat (3) @(posedge hclk);
			pm.watch(mh_m, nl_m);
			chk("module lamp", MH_EXP[i], mh_m);
		end
		// timeout flag survives the duplicate step, so priority shows
		for (i = 0; i < 6; i++) begin
			{ip_assigned, cip_connected, eo_timeout_evt, eo_all_restored, dup_ip} <= NL_IN[i];
			repeat (3) @(posedge hclk);
			pm.watch(mh_m, nl_m);
			chk("network lamp", NL_EXP[i], nl_m);
		end
		ahb(1'b0, OFS_STATUS, 32'h0);
		chk("status", (32'(NL_CONN) << ST_NL_LSB) | (32'(MH_UNREC) << ST_MH_LSB) | (32'h1 << ST_OPER), rd);
		chk("bus response", 32'h0, hresp);
		ahb(1'b1, OFS_IRQ_EN, 32'h2);
		pm.press(3);
		repeat (3) @(posedge hclk);
		chk("dark correction pulses", 1, dark_n);
		chk("interrupt raised", 1'b1, irq);
		ahb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk("event status", 32'h1b, rd);
		ahb(1'b1, OFS_IRQ_EN, 32'h0);
		repeat (2) @(posedge hclk);
		chk("interrupt masked", 1'b0, irq);
		ahb(1'b1, OFS_IRQ_CLR, 32'h1f);
		ahb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk("status cleared", 32'h0, rd);
		ahb(1'b0, OFS_NONE, 32'h0);
		chk("unmapped read", 32'h0, rd);
		for (i = 1; i < 3; i++) begin
			ahb(1'b1, OFS_CTRL, 32'(i) << 2);
			pm.press(HOLD + 10);
			repeat (3) @(posedge hclk);
			chk("ignored press", 1, dark_n);
			chk("ignored hold", 0, fact_n);
		end
		ahb(1'b1, OFS_CTRL, 32'h2);
		pm.press(HOLD - 5);
		repeat (3) @(posedge hclk);
		chk("short hold", 0, fact_n);
		pm.press(HOLD + 5);
		repeat (3) @(posedge hclk);
		chk("long hold", 1, fact_n);
		chk("dark on each press", 3, dark_n);
		ahb(1'b0, OFS_CTRL, 32'h0);
		chk("settings restored", 32'h0, rd);
		do_reset(1'b1, 1'b1);
		repeat (3) @(posedge hclk);
		chk("saved operating mode", 1'b1, op_mode);
		end_of_test();
	end
endmodule
